/* pipeline_regs.svh */
`ifndef PIPELINE_REGS_SVH
`define PIPELINE_REGS_SVH

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_DONE_BIT 1
`define INTERP_CLEAR_BIT 2
`define POL_H_BIT 0
`define POL_V_BIT 1

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define DEFECT_CTRL_W 2
`define INTERP_CTRL_W 4
`define POL_W 2
`define BAYER_W 2
`define IRQ_CTRL_W 18
`define STATUS_W 18
`define POL_RESET 2'h3
`define BAYER_RESET 2'h0
`define STATUS_RESET 18'h00000
`define IRQ_CTRL_RESET 18'h00000

`endif

/* pipeline_pkg.sv */
package pipeline_pkg;
    typedef enum logic [0:0] {
        frame_active,
        frame_blanking
    } frame_phase_e;
endpackage : pipeline_pkg

/* frame_if.sv */
`timescale 1ns/1ps
interface frame_if;
    logic vblank;
    logic vertical_high;
    logic frame_end;
    modport detector (input vblank, input vertical_high, output frame_end);
    modport consumer (output vblank, output vertical_high, input frame_end);
endinterface : frame_if

/* frame_end_detect.sv */
`timescale 1ns/1ps
`include "pipeline_regs.svh"
module frame_end_detect
    import pipeline_pkg::*;
(
    // Clock and resets
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sclr,
    // Frame signals
    frame_if.detector frame
);
    typedef struct packed {
        frame_phase_e phase;
        logic frame_end;
    } det_s;

    det_s state;
    det_s next_state;
    logic blanking;

    always_comb begin
        // Normalise the vertical blanking level to asserted-high.
        blanking = ~(frame.vblank ^ frame.vertical_high);
        next_state = state;
        next_state.frame_end = 1'b0;
        case (state.phase)
            frame_active: begin
                if (blanking) begin
                    next_state.phase = frame_blanking;
                    next_state.frame_end = 1'b1;
                end
            end
            frame_blanking: begin
                if (!blanking) begin
                    next_state.phase = frame_active;
                end
            end
            default: begin
                next_state.phase = frame_active;
            end
        endcase
        if (sclr) begin
            next_state.phase = frame_active;
            next_state.frame_end = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= '{phase: frame_active, frame_end: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign frame.frame_end = state.frame_end;
endmodule : frame_end_detect

/* pipeline_host_config_ports.sv */
`timescale 1ns/1ps
`include "pipeline_regs.svh"
module pipeline_host_config_ports
    import pipeline_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int COLS_WIDTH = 12,
    parameter int ROWS_WIDTH = 12
) (
    // Clock and resets
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sclr,
    // Timing inputs
    input wire logic hblank_in,
    input wire logic vblank_in,
    // Defect correction settings
    input wire logic [`DEFECT_CTRL_W-1:0] defect_control,
    input wire logic [WIDTH-1:0] defect_neighbour_threshold,
    input wire logic [WIDTH-1:0] defect_same_colour_threshold,
    // Interpolation settings
    input wire logic [`INTERP_CTRL_W-1:0] interp_control,
    input wire logic [COLS_WIDTH-1:0] active_left_in,
    input wire logic [COLS_WIDTH-1:0] active_right_in,
    input wire logic [ROWS_WIDTH-1:0] active_top_in,
    input wire logic [ROWS_WIDTH-1:0] active_bottom_in,
    input wire logic [COLS_WIDTH-1:0] total_rows_in,
    input wire logic [COLS_WIDTH-1:0] total_cols_in,
    input wire logic [ROWS_WIDTH-1:0] blank_rows_in,
    input wire logic [COLS_WIDTH-1:0] blank_left_in,
    input wire logic [COLS_WIDTH-1:0] blank_right_in,
    input wire logic [`POL_W-1:0] blank_polarity_in,
    input wire logic [`BAYER_W-1:0] bayer_phase_in,
    input wire logic [`IRQ_CTRL_W-1:0] irq_control,
    // Status events from the datapath
    input wire logic [`STATUS_W-1:0] status_event,
    // Working defect settings
    output logic defect_enable,
    output logic [WIDTH-1:0] defect_neighbour_threshold_out,
    output logic [WIDTH-1:0] defect_same_colour_threshold_out,
    // Working interpolation settings
    output logic interp_enable,
    output logic [COLS_WIDTH-1:0] active_left_out,
    output logic [COLS_WIDTH-1:0] active_right_out,
    output logic [ROWS_WIDTH-1:0] active_top_out,
    output logic [ROWS_WIDTH-1:0] active_bottom_out,
    output logic [COLS_WIDTH-1:0] total_rows_out,
    output logic [COLS_WIDTH-1:0] total_cols_out,
    output logic [ROWS_WIDTH-1:0] blank_rows_out,
    output logic [COLS_WIDTH-1:0] blank_left_out,
    output logic [COLS_WIDTH-1:0] blank_right_out,
    output logic [`POL_W-1:0] blank_polarity_out,
    output logic [`BAYER_W-1:0] bayer_phase_out,
    output logic [`IRQ_CTRL_W-1:0] irq_control_out,
    // Status and timing
    output logic [`STATUS_W-1:0] interp_status,
    output logic hblank_asserted,
    output logic vblank_asserted,
    output logic settings_loaded
);
    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (WIDTH < 1 || COLS_WIDTH < 1 || ROWS_WIDTH < 1) begin : g_bad_width
        $error("pipeline_host_config_ports: widths must be at least one");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic defect_enable;
        logic [WIDTH-1:0] neighbour_thr;
        logic [WIDTH-1:0] same_colour_thr;
        logic interp_enable;
        logic [COLS_WIDTH-1:0] active_left;
        logic [COLS_WIDTH-1:0] active_right;
        logic [ROWS_WIDTH-1:0] active_top;
        logic [ROWS_WIDTH-1:0] active_bottom;
        logic [COLS_WIDTH-1:0] total_rows;
        logic [COLS_WIDTH-1:0] total_cols;
        logic [ROWS_WIDTH-1:0] blank_rows;
        logic [COLS_WIDTH-1:0] blank_left;
        logic [COLS_WIDTH-1:0] blank_right;
        logic [`POL_W-1:0] polarity;
        logic [`BAYER_W-1:0] bayer;
        logic [`IRQ_CTRL_W-1:0] irq_ctl;
        logic [`STATUS_W-1:0] status;
        logic h_asserted;
        logic v_asserted;
        logic loaded;
    } cfg_s;

    localparam cfg_s CFG_RESET = '{
        polarity: `POL_RESET,
        bayer: `BAYER_RESET,
        irq_ctl: `IRQ_CTRL_RESET,
        status: `STATUS_RESET,
        default: '0
    };

    cfg_s state;
    cfg_s next_state;

    // ------------------------------------------------------------------
    // Frame end detection
    // ------------------------------------------------------------------
    frame_if frame ();

    assign frame.vblank = vblank_in;
    // The detector follows the working polarity so that a polarity change
    // written mid-frame cannot fake an end of frame.
    assign frame.vertical_high = state.polarity[`POL_V_BIT];

    frame_end_detect u_frame_end (
        .clock(clock),
        .rst_b(rst_b),
        .sclr(sclr),
        .frame(frame.detector)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.loaded = 1'b0;
        next_state.h_asserted = ~(hblank_in ^ state.polarity[`POL_H_BIT]);
        next_state.v_asserted = ~(vblank_in ^ state.polarity[`POL_V_BIT]);
        if (interp_control[`INTERP_CLEAR_BIT]) begin
            next_state.status = status_event;
        end else begin
            next_state.status = state.status | status_event;
        end
        if (frame.frame_end) begin
            if (defect_control[`CTRL_DONE_BIT]) begin
                next_state.defect_enable = defect_control[`CTRL_ENABLE_BIT];
                next_state.neighbour_thr = defect_neighbour_threshold;
                next_state.same_colour_thr = defect_same_colour_threshold;
                next_state.loaded = 1'b1;
            end
            if (interp_control[`CTRL_DONE_BIT]) begin
                next_state.interp_enable = interp_control[`CTRL_ENABLE_BIT];
                next_state.active_left = active_left_in;
                next_state.active_right = active_right_in;
                next_state.active_top = active_top_in;
                next_state.active_bottom = active_bottom_in;
                next_state.total_rows = total_rows_in;
                next_state.total_cols = total_cols_in;
                next_state.blank_rows = blank_rows_in;
                next_state.blank_left = blank_left_in;
                next_state.blank_right = blank_right_in;
                next_state.polarity = blank_polarity_in;
                next_state.bayer = bayer_phase_in;
                next_state.irq_ctl = irq_control;
                next_state.loaded = 1'b1;
            end
        end
        if (sclr) begin
            next_state = CFG_RESET;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= CFG_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign defect_enable = state.defect_enable;
    assign defect_neighbour_threshold_out = state.neighbour_thr;
    assign defect_same_colour_threshold_out = state.same_colour_thr;
    assign interp_enable = state.interp_enable;
    assign active_left_out = state.active_left;
    assign active_right_out = state.active_right;
    assign active_top_out = state.active_top;
    assign active_bottom_out = state.active_bottom;
    assign total_rows_out = state.total_rows;
    assign total_cols_out = state.total_cols;
    assign blank_rows_out = state.blank_rows;
    assign blank_left_out = state.blank_left;
    assign blank_right_out = state.blank_right;
    assign blank_polarity_out = state.polarity;
    assign bayer_phase_out = state.bayer;
    assign irq_control_out = state.irq_ctl;
    assign interp_status = state.status;
    assign hblank_asserted = state.h_asserted;
    assign vblank_asserted = state.v_asserted;
    assign settings_loaded = state.loaded;
endmodule : pipeline_host_config_ports

/* pipeline_host_config_ports_checker.sv */
`timescale 1ns/1ps
`include "pipeline_regs.svh"
module pipeline_host_config_ports_checker
    import pipeline_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int COLS_WIDTH = 12
) (
    // Inputs
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sclr,
    input wire logic hblank_in,
    input wire logic [`DEFECT_CTRL_W-1:0] defect_control,
    input wire logic [WIDTH-1:0] defect_neighbour_threshold,
    input wire logic [`INTERP_CTRL_W-1:0] interp_control,
    input wire logic [COLS_WIDTH-1:0] active_left_in,
    input wire logic [`POL_W-1:0] blank_polarity_in,
    input wire logic [`STATUS_W-1:0] status_event,
    // Outputs
    input wire logic defect_enable,
    input wire logic [WIDTH-1:0] defect_neighbour_threshold_out,
    input wire logic interp_enable,
    input wire logic [COLS_WIDTH-1:0] active_left_out,
    input wire logic [`POL_W-1:0] blank_polarity_out,
    input wire logic [`STATUS_W-1:0] interp_status,
    input wire logic hblank_asserted,
    input wire logic vblank_asserted,
    input wire logic settings_loaded
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_load_pulse: assert property (
        $rose(vblank_asserted) && (defect_control[1] || interp_control[1]) && !sclr
        |=> settings_loaded)
        else $error("load pulse missing");
    a_defect_take: assert property ($rose(vblank_asserted) && defect_control[1] && !sclr |=>
        defect_enable == $past(defect_control[0])
        && defect_neighbour_threshold_out == $past(defect_neighbour_threshold))
        else $error("defect set not taken");
    a_defect_hold: assert property (
        !($rose(vblank_asserted) && defect_control[1]) && !sclr |=>
        $stable(defect_enable) && $stable(defect_neighbour_threshold_out))
        else $error("defect set changed");
    a_interp_take: assert property ($rose(vblank_asserted) && interp_control[1] && !sclr |=>
        active_left_out == $past(active_left_in) && interp_enable == $past(interp_control[0])
        && blank_polarity_out == $past(blank_polarity_in))
        else $error("interp set not taken");
    a_interp_hold: assert property (
        !($rose(vblank_asserted) && interp_control[1]) && !sclr |=>
        $stable(active_left_out) && $stable(blank_polarity_out) && $stable(interp_enable))
        else $error("interp set changed");
    a_status_clear: assert property (interp_control[2] && !sclr |=>
        interp_status == $past(status_event))
        else $error("status not cleared");
    a_status_sticky: assert property (!interp_control[2] && !sclr |=>
        interp_status == ($past(interp_status) | $past(status_event)))
        else $error("status not sticky");
    a_hblank_norm: assert property (!sclr |=>
        hblank_asserted == ~($past(hblank_in) ^ $past(blank_polarity_out[0])))
        else $error("hblank polarity wrong");
endmodule : pipeline_host_config_ports_checker

/* host_model.sv */
`timescale 1ns/1ps
module host_model (
    // Clock and requests
    input wire logic clock,
    input wire logic go,
    input wire logic clr,
    input wire logic [11:0] val,
    input wire logic [1:0] en,
    input wire logic [1:0] done,
    // Configuration ports
    output logic [1:0] defect_control,
    output logic [3:0] interp_control,
    output logic [11:0] g
);
    logic [1:0] en_r = 2'h0;
    logic [1:0] done_r = 2'h0;
    initial g = 12'h000;
    // reserved bit set
    // The reserved bit is held high so that any use of it shows up.
    assign defect_control = {done_r[0], en_r[0]};
    assign interp_control = {1'b1, clr, done_r[1], en_r[1]};
    always @(posedge clock) begin
        if (go) begin
            @(negedge clock);
            done_r <= 2'h0;
            @(negedge clock);
            g <= val;
            en_r <= en;
            @(negedge clock);
            done_r <= done;
        end
    end
endmodule : host_model

/* pipeline_host_config_ports_tb.sv */
`timescale 1ns/1ps
`include "pipeline_regs.svh"
module pipeline_host_config_ports_tb
    import pipeline_pkg::*;
;
    typedef struct {logic [11:0] g; logic [1:0] en, done; logic [11:0] left;
        logic [7:0] thr; logic [1:0] en_out; int loads;} row_s;
    row_s rows [5] = '{'{12'h123, 2'h3, 2'h3, 12'h123, 8'h23, 2'h3, 1},
        '{12'h456, 2'h0, 2'h0, 12'h123, 8'h23, 2'h3, 1},
        '{12'h789, 2'h0, 2'h1, 12'h123, 8'h89, 2'h2, 2},
        '{12'habc, 2'h3, 2'h2, 12'habc, 8'h89, 2'h2, 3},
        '{12'hfff, 2'h1, 2'h3, 12'hfff, 8'hff, 2'h1, 4}};
    logic clock, rst_b, sclr, hblank_in, vblank_in, go, clr, d_en, i_en, hb, vb, loaded;
    logic [11:0] val, g, left, right, top, bottom, trows, tcols, brows, bleft, bright;
    logic [1:0] en, done, pol, pol_out, dctl, bayer;
    logic [3:0] ictl;
    logic [7:0] thr, same;
    logic [17:0] status_event, status, irq;
    int n_mismatch = 0, n_checks = 0, loads = 0;
    host_model i_host_model (.clock(clock), .go(go), .clr(clr), .val(val), .en(en),
        .done(done), .defect_control(dctl), .interp_control(ictl), .g(g));
    pipeline_host_config_ports i_pipeline_host_config_ports (.clock(clock), .rst_b(rst_b),
        .sclr(sclr), .hblank_in(hblank_in), .vblank_in(vblank_in), .defect_control(dctl),
        .defect_neighbour_threshold(g[7:0]), .defect_same_colour_threshold(~g[7:0]),
        .interp_control(ictl), .active_left_in(g), .active_right_in(g + 12'h1),
        .active_top_in(g + 12'h2), .active_bottom_in(g + 12'h3), .total_rows_in(g + 12'h4),
        .total_cols_in(g + 12'h5), .blank_rows_in(g + 12'h6), .blank_left_in(g + 12'h7),
        .blank_right_in(g + 12'h8), .blank_polarity_in(pol), .bayer_phase_in(g[3:2]),
        .irq_control({6'h00, g}), .status_event(status_event), .defect_enable(d_en),
        .defect_neighbour_threshold_out(thr), .defect_same_colour_threshold_out(same),
        .interp_enable(i_en), .active_left_out(left), .active_right_out(right),
        .active_top_out(top), .active_bottom_out(bottom), .total_rows_out(trows),
        .total_cols_out(tcols), .blank_rows_out(brows), .blank_left_out(bleft),
        .blank_right_out(bright), .blank_polarity_out(pol_out), .bayer_phase_out(bayer),
        .irq_control_out(irq),
        .interp_status(status), .hblank_asserted(hb), .vblank_asserted(vb),
        .settings_loaded(loaded));
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // The host update runs its full handshake before the frame edge arrives.
    task automatic update(logic [11:0] v, logic [1:0] e, logic [1:0] d);
        val = v;
        en = e;
        done = d;
        go = 1'b1;
        @(negedge clock);
        go = 1'b0;
        repeat (6) @(negedge clock);
        vblank_in = 1'b1;
        repeat (4) @(negedge clock);
        vblank_in = 1'b0;
    endtask : update
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) if (loaded === 1'b1) loads++;
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        {rst_b, sclr, hblank_in, vblank_in, go, clr, val, en, done, status_event} = '0;
        pol = 2'h3;
        repeat (4) @(negedge clock);
        rst_b = 1'b1;
        check("left", left, 0);
        check("pol", pol_out, 2'h3);
        check("status", status, 0);
        foreach (rows[i]) begin
            update(rows[i].g, rows[i].en, rows[i].done);
            check("left", left, rows[i].left);
            check("right", right, 12'(rows[i].left + 12'h1));
            check("top", top, 12'(rows[i].left + 12'h2));
            check("bottom", bottom, 12'(rows[i].left + 12'h3));
            check("trows", trows, 12'(rows[i].left + 12'h4));
            check("tcols", tcols, 12'(rows[i].left + 12'h5));
            check("brows", brows, 12'(rows[i].left + 12'h6));
            check("bleft", bleft, 12'(rows[i].left + 12'h7));
            check("bright", bright, 12'(rows[i].left + 12'h8));
            check("bayer", bayer, rows[i].left[3:2]);
            check("irq", irq, {6'h00, rows[i].left});
            check("thr", thr, rows[i].thr);
            check("same", same, 8'(~rows[i].thr));
            check("en", {i_en, d_en}, rows[i].en_out);
            check("loads", loads, rows[i].loads);
        end
        pol = 2'h0;
        update(12'h321, 2'h3, 2'h2);
        hblank_in = 1'b1;
        @(negedge clock);
        check("hb", hb, 1'b0);
        check("vb", vb, 1'b1);
        status_event = 18'h00020;
        @(negedge clock);
        status_event = '0;
        @(negedge clock);
        check("status", status, 18'h00020);
        clr = 1'b1;
        status_event = 18'h00001;
        @(negedge clock);
        status_event = '0;
        check("status", status, 18'h00001);
        @(negedge clock);
        clr = 1'b0;
        check("status", status, 0);
        sclr = 1'b1;
        @(negedge clock);
        sclr = 1'b0;
        check("left", left, 0);
        check("pol", pol_out, 2'h3);
        give_verdict();
    end
endmodule : pipeline_host_config_ports_tb
bind pipeline_host_config_ports pipeline_host_config_ports_checker #(.WIDTH(WIDTH),
    .COLS_WIDTH(COLS_WIDTH)) i_checker (.clock, .rst_b, .sclr, .hblank_in, .defect_control,
    .defect_neighbour_threshold, .interp_control, .active_left_in, .blank_polarity_in,
    .status_event, .defect_enable, .defect_neighbour_threshold_out, .interp_enable,
    .active_left_out, .blank_polarity_out, .interp_status, .hblank_asserted,
    .vblank_asserted, .settings_loaded);
